/* File: pwm_load_model.sv */
// load model standing on the shared modulator pin
`timescale 1ns/1ps
module pwm_load_model (
   input wire logic clk_sys,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic pullup_en,
   output logic pin_in
);
   logic wiggle = 1'b0;
   // ==========================================
   // floating line pattern
   always @(posedge clk_sys) begin
      wiggle <= ~wiggle;
   end
   // ==========================================
   // wire level seen by the pin input
   // pull-high on input
   always_comb begin
      if (pin_oe) begin
         pin_in = pin_out;
      end else if (pullup_en) begin
         pin_in = 1'b1;
      end else begin
         pin_in = wiggle;
      end
   end
endmodule

/* File: pwm_sub_cycle_gen.sv */
// waveform generator: 256-clock cycle split into 7+1 or 6+2 sub-cycles
`timescale 1ns/1ps
module pwm_sub_cycle_gen
   import pwm_sub_cycle_pkg::*;
#(
   parameter int WIDTH = DUTY_W
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] duty,
   input wire logic mode_7p1,
   output logic pwm_out,
   output logic [WIDTH-1:0] cnt
);
   // elaboration check: only an 8-bit duty fills the 256-clock cycle
   if (WIDTH != 8 || (1 << WIDTH) != CYCLE_LEN) begin : g_width_check
      $error("pwm_sub_cycle_gen supports only an 8-bit duty");
   end

   logic [WIDTH-1:0] duty_q;
   logic mode_q;
   logic [WIDTH-1:0] pos;
   logic [WIDTH-1:0] limit;

   // =========================================
   // free-running cycle counter
   // 256-clock cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + WIDTH'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         duty_q <= '0;
         mode_q <= 1'b0;
      end else if (cnt == CNT_LAST) begin
         duty_q <= duty;
         mode_q <= mode_7p1;
      end
   end

   // =========================================
   // per sub-cycle high count
   always_comb begin
      if (mode_q) begin
         pos = {1'b0, cnt[6:0]};
         limit = {1'b0, duty_q[7:1]} + {7'h00, (cnt[7] < duty_q[0])};
      end else begin
         pos = {2'b00, cnt[5:0]};
         limit = {2'b00, duty_q[7:2]} + {7'h00, (cnt[7:6] < duty_q[1:0])};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= (pos < limit);
      end
   end

   // =========================================
   // checks
   a_cycle_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
      cnt == CNT_LAST |=> cnt == '0) else $error("cycle counter did not wrap");
   a_duty_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      cnt != CNT_LAST |=> $stable(duty_q) && $stable(mode_q))
      else $error("duty changed mid cycle");
   a_extra_first: assert property (@(posedge clk_sys) disable iff (!resetn)
      mode_q && duty_q == 8'h01 && cnt == '0 |=> pwm_out ##1 !pwm_out)
      else $error("7+1 extra pulse wrong in sub-cycle 0");
   a_noextra_second: assert property (@(posedge clk_sys) disable iff (!resetn)
      mode_q && duty_q == 8'h01 && cnt == SUB1_START_7P1 |=> !pwm_out)
      else $error("7+1 extra pulse leaked into sub-cycle 1");
   a_six_two_extra: assert property (@(posedge clk_sys) disable iff (!resetn)
      !mode_q && duty_q == 8'h07 && cnt == SUB3_START_6P2 |=> pwm_out ##1 !pwm_out)
      else $error("6+2 last quarter pulse wrong");
   c_mode_7p1: cover property (@(posedge clk_sys) disable iff (!resetn)
      mode_q && cnt == CNT_LAST);
   c_mode_6p2: cover property (@(posedge clk_sys) disable iff (!resetn)
      !mode_q && duty_q != '0 && cnt == CNT_LAST);
endmodule

/* File: pwm_sub_cycle_modulator.sv */
// pulse width modulator channel with ahb-lite registers and shared pin
//
// How it works
// - one full output cycle always lasts 256 system clocks.
// - 7+1 mode splits the cycle into two 128-clock sub-cycles.
// - 7+1 mode: duty bits 7..1 are base, bit 0 is extra.
// - sub-cycle index below extra gets base plus one high clocks.
// - pin driven by modulator only when its function-select bit is set.
// - selected and output: data one passes waveform, zero holds pin low.
// - selected but direction input: pin is plain input, with pull-high only when its pull-up register bit is set.
// - control bit 5 selects the 7+1 mode.
// - control bit 3 gives the first channel pin to the modulator.
// - counter runs straight from the system clock, cycle rate clk/256.
// - 6+2 mode: four 64-clock sub-cycles, bits 7..2 base, 1..0 extra.
// - the channel has its own 8-bit duty register.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module pwm_sub_cycle_modulator
   import pwm_sub_cycle_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic port_a_bit4_pin_in,
   output logic port_a_bit4_pin_out,
   output logic port_a_bit4_pin_oe,
   output logic port_a_bit4_pullup_en
);
   // =========================================
   // registers and state
   logic [7:0] first_channel_duty_reg;
   logic [7:0] first_control_reg;
   logic [7:0] port_a_direction_reg;
   logic [7:0] port_a_output_data_reg;
   logic [7:0] port_a_pullup_reg;
   logic [7:0] addr_reg;
   logic wr_pend_reg;
   bus_state_e bus_state_reg;
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pwm_wave;
   logic [7:0] pwm_cnt;
   logic addr_phase;
   logic fn_sel;
   logic pin_is_out;

   assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
   assign fn_sel = first_control_reg[CTRL_SEL_BIT];
   assign pin_is_out = !port_a_direction_reg[PIN_BIT];

   function automatic logic [31:0] reg_read(input logic [7:0] a);
      logic [31:0] v;
      v = '0;
      case (a)
         OFF_DUTY: v[7:0] = first_channel_duty_reg;
         OFF_CTRL: v[7:0] = first_control_reg;
         OFF_DIR: v[7:0] = port_a_direction_reg;
         OFF_DATA: v[7:0] = port_a_output_data_reg;
         OFF_STATUS: begin
            v[7:0] = pwm_cnt;
            v[STAT_PWM_BIT] = pwm_wave;
            v[STAT_PIN_BIT] = pin_sync_reg;
         end
         OFF_PULL: v[7:0] = port_a_pullup_reg;
         default: v = '0;
      endcase
      return v;
   endfunction

   // =========================================
   // ahb-lite slave: writes zero wait, reads one wait
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         addr_reg <= 8'h00;
         wr_pend_reg <= 1'b0;
         bus_state_reg <= BUS_IDLE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;
         case (bus_state_reg)
            BUS_IDLE: begin
               wr_pend_reg <= addr_phase && hwrite;
               if (addr_phase) begin
                  addr_reg <= haddr[7:0];
               end
               if (addr_phase && !hwrite) begin
                  bus_state_reg <= BUS_READ_WAIT;
                  hreadyout <= 1'b0;
               end
            end
            BUS_READ_WAIT: begin
               wr_pend_reg <= 1'b0;
               hrdata <= reg_read(addr_reg);
               hreadyout <= 1'b1;
               bus_state_reg <= BUS_IDLE;
            end
            default: begin
               bus_state_reg <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         first_channel_duty_reg <= DUTY_RST;
      end else if (wr_pend_reg && addr_reg == OFF_DUTY) begin
         first_channel_duty_reg <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         first_control_reg <= CTRL_RST;
      end else if (wr_pend_reg && addr_reg == OFF_CTRL) begin
         first_control_reg <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         port_a_direction_reg <= DIR_RST;
         port_a_output_data_reg <= DATA_RST;
         port_a_pullup_reg <= PULL_RST;
      end else if (wr_pend_reg) begin
         if (addr_reg == OFF_DIR) begin
            port_a_direction_reg <= hwdata[7:0];
         end
         if (addr_reg == OFF_DATA) begin
            port_a_output_data_reg <= hwdata[7:0];
         end
         if (addr_reg == OFF_PULL) begin
            port_a_pullup_reg <= hwdata[7:0];
         end
      end
   end

   // =========================================
   // waveform generator
   pwm_sub_cycle_gen #(
      .WIDTH(DUTY_W)
   ) u_gen (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .duty(first_channel_duty_reg),
      .mode_7p1(first_control_reg[CTRL_MODE_BIT]),
      .pwm_out(pwm_wave),
      .cnt(pwm_cnt)
   );

   // =========================================
   // pin input synchroniser
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= port_a_bit4_pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // =========================================
   // shared pin drive
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         port_a_bit4_pin_out <= 1'b0;
         port_a_bit4_pin_oe <= 1'b0;
         port_a_bit4_pullup_en <= 1'b0;
      end else begin
         port_a_bit4_pin_oe <= pin_is_out;
         port_a_bit4_pullup_en <= !pin_is_out && port_a_pullup_reg[PIN_BIT];
         if (fn_sel) begin
            port_a_bit4_pin_out <= port_a_output_data_reg[PIN_BIT] && pwm_wave;
         end else begin
            port_a_bit4_pin_out <= port_a_output_data_reg[PIN_BIT];
         end
      end
   end

   // =========================================
   // checks
   a_pin_forced_low: assert property (@(posedge clk_sys) disable iff (!resetn)
      fn_sel && pin_is_out && !port_a_output_data_reg[PIN_BIT]
      |=> port_a_bit4_pin_oe && !port_a_bit4_pin_out)
      else $error("pin not held low with data bit zero");
   a_pin_pass_wave: assert property (@(posedge clk_sys) disable iff (!resetn)
      fn_sel && pin_is_out && port_a_output_data_reg[PIN_BIT]
      |=> port_a_bit4_pin_out == $past(pwm_wave))
      else $error("waveform not passed to pin");
   a_pin_input: assert property (@(posedge clk_sys) disable iff (!resetn)
      !pin_is_out |=> !port_a_bit4_pin_oe)
      else $error("pin driven while set as input");
   a_gpio_plain: assert property (@(posedge clk_sys) disable iff (!resetn)
      !fn_sel |=> port_a_bit4_pin_out == $past(port_a_output_data_reg[PIN_BIT]))
      else $error("modulator drove pin without selection");
   a_read_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
      bus_state_reg == BUS_IDLE && addr_phase && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer not after one wait");
   a_mode_write: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_pend_reg && addr_reg == OFF_CTRL
      |=> first_control_reg[CTRL_MODE_BIT] == $past(hwdata[CTRL_MODE_BIT]))
      else $error("mode bit not written");
   c_pin_wave: cover property (@(posedge clk_sys) disable iff (!resetn)
      fn_sel && pin_is_out && port_a_bit4_pin_out);
   c_bus_read: cover property (@(posedge clk_sys) disable iff (!resetn)
      bus_state_reg == BUS_READ_WAIT);
endmodule

/* File: pwm_sub_cycle_pkg.sv */
// shared constants for the sub-cycle pulse width modulator
package pwm_sub_cycle_pkg;
   // =========================================
   // clock and cycle timing
   localparam int CLK_HZ = 50000000;
   localparam int DUTY_W = 8;
   localparam int CYCLE_LEN = 256;
   localparam logic [7:0] CNT_LAST = 8'hff;
   localparam logic [7:0] SUB1_START_7P1 = 8'h80;
   localparam logic [7:0] SUB3_START_6P2 = 8'hc0;
   // =========================================
   // register byte offsets
   localparam logic [7:0] OFF_DUTY = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_DIR = 8'h08;
   localparam logic [7:0] OFF_DATA = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_PULL = 8'h14;
   // =========================================
   // field positions
   localparam int CTRL_SEL_BIT = 3;
   localparam int CTRL_MODE_BIT = 5;
   localparam int PIN_BIT = 4;
   localparam int STAT_PWM_BIT = 8;
   localparam int STAT_PIN_BIT = 9;
   // =========================================
   // reset values and bus encodings
   localparam logic [7:0] DUTY_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] PULL_RST = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [0:0] {BUS_IDLE, BUS_READ_WAIT} bus_state_e;
endpackage

/* File: testbench.sv */
// self-checking bench for the sub-cycle modulator
`timescale 1ns/1ps
module testbench;
   import pwm_sub_cycle_pkg::*;
   logic clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
   logic pin_in, pin_out, pin_oe, pull_en;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int p[4];
   pwm_sub_cycle_modulator dut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .port_a_bit4_pin_in(pin_in), .port_a_bit4_pin_out(pin_out),
      .port_a_bit4_pin_oe(pin_oe), .port_a_bit4_pullup_en(pull_en));
   pwm_load_model load (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pull_en), .pin_in(pin_in));
   // ==========================================
   // clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   // ==========================================
   // shared tasks
   task automatic tally_and_finish();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h00000000;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask
   task automatic pulse(output int n);
      n = 0;
      while (pin_out !== 1'b0) @(posedge clk_sys);
      while (pin_out !== 1'b1) @(posedge clk_sys);
      while (pin_out === 1'b1) begin
         n++;
         @(posedge clk_sys);
      end
   endtask
   task automatic steady(input logic v);
      int bad;
      bad = 0;
      repeat (300) begin
         @(posedge clk_sys);
         bad += (pin_out !== v);
      end
      check(bad, 0);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      logic [7:0] offs[6];
      logic [7:0] vals[6];
      offs = '{OFF_DUTY, OFF_CTRL, OFF_DIR, OFF_DATA, OFF_PULL, 8'h18};
      vals = '{DUTY_RST, CTRL_RST, DIR_RST, DATA_RST, PULL_RST, 8'h00};
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, offs[i], 32'h0);
         check(rd, {24'h000000, vals[i]});
         check(hresp, 1'b0);
      end
   endtask
   task automatic t_sub71();
      xfer(1'b1, OFF_DUTY, 32'h65);
      xfer(1'b1, OFF_CTRL, 32'h28);
      xfer(1'b1, OFF_DIR, 32'hef);
      xfer(1'b1, OFF_DATA, 32'h10);
      repeat (600) @(posedge clk_sys);
      pulse(p[0]);
      pulse(p[1]);
      check(p[0] + p[1], 32'h65);
      check((p[0] < p[1]) ? p[0] : p[1], 32'h65 >> 1);
      check((p[0] > p[1]) ? p[0] - p[1] : p[1] - p[0], 1);
      check(pin_oe, 1'b1);
   endtask
   task automatic t_sub62();
      int longs;
      longs = 0;
      xfer(1'b1, OFF_CTRL, 32'h08);
      xfer(1'b1, OFF_DUTY, 32'h0e);
      repeat (600) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         pulse(p[i]);
         longs += (p[i] == 4);
      end
      check(p[0] + p[1] + p[2] + p[3], 32'h0e);
      check(longs, 2);
   endtask
   task automatic t_off();
      xfer(1'b1, OFF_DATA, 32'h00);
      repeat (4) @(posedge clk_sys);
      steady(1'b0);
   endtask
   task automatic t_gpio();
      xfer(1'b1, OFF_CTRL, 32'h00);
      xfer(1'b1, OFF_DATA, 32'h10);
      repeat (4) @(posedge clk_sys);
      steady(1'b1);
   endtask
   task automatic t_input();
      xfer(1'b1, OFF_CTRL, 32'h28);
      xfer(1'b1, OFF_DIR, 32'hff);
      xfer(1'b1, OFF_PULL, 32'h10);
      repeat (4) @(posedge clk_sys);
      check(pin_oe, 1'b0);
      check(pull_en, 1'b1);
      xfer(1'b0, OFF_STATUS, 32'h0);
      check(rd[STAT_PIN_BIT], 1'b1);
   endtask
   task automatic t_thin();
      int longs;
      xfer(1'b1, OFF_DIR, 32'hef);
      xfer(1'b1, OFF_CTRL, 32'h28);
      xfer(1'b1, OFF_DUTY, 32'h01);
      repeat (600) @(posedge clk_sys);
      pulse(p[0]);
      p[1] = 0;
      while (pin_out !== 1'b1) begin
         p[1]++;
         @(posedge clk_sys);
      end
      check(p[0], 1);
      check(p[0] + p[1], 256);
      xfer(1'b1, OFF_CTRL, 32'h08);
      xfer(1'b1, OFF_DUTY, 32'h07);
      repeat (600) @(posedge clk_sys);
      longs = 0;
      for (int i = 0; i < 4; i++) begin
         pulse(p[i]);
         longs += (p[i] == 2);
      end
      check(p[0] + p[1] + p[2] + p[3], 7);
      check(longs, 3);
   endtask
   task automatic t_mid_reset();
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      check(pin_oe, 1'b0);
      t_reset();
   endtask
   // ==========================================
   // main sequence
   initial begin
      resetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_sub71();
      t_sub62();
      t_off();
      t_gpio();
      t_input();
      t_thin();
      t_mid_reset();
      tally_and_finish();
   end
endmodule
